// ===== src/mbp_pkg.sv
package mbp_pkg;
	localparam int          BUS_W        = 32;
	localparam int          BYTE_LANES   = 4;
	localparam int          BURST_WORDS  = 4;
	localparam logic [1:0]  IDX_ZERO     = 2'h0;
	localparam logic [1:0]  IDX_ONE      = 2'h1;
	localparam int          ADDR_HI_LSB  = 4;
	localparam int          IDX_LSB      = 2;
	localparam int          DIAG_HI_BIT  = 3;
	localparam int          DIAG_LO_BIT  = 2;
	localparam logic [2:0]  BURST_LAST   = 3'h3;
	localparam logic [2:0]  CNT_ZERO     = 3'h0;
	localparam logic [2:0]  CNT_ONE      = 3'h1;

	typedef enum logic [5:0] {
		MBP_IDLE   = 6'h01,
		MBP_ADDR   = 6'h02,
		MBP_HOLD   = 6'h04,
		MBP_WRITE  = 6'h08,
		MBP_READ   = 6'h10,
		MBP_DONE   = 6'h20
	} mbp_state_type;
endpackage

// ===== src/mbp_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module mbp_sync (
	input  wire logic clk_in,     // system clock
	input  wire logic resetn_in,  // async reset, active low
	input  wire logic async_in,   // pin level
	output logic      level_out   // filtered level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} mbp_sync_type;

	mbp_sync_type r_q;
	mbp_sync_type r_d;

	always_comb begin
		r_d    = r_q;
		r_d.s1 = async_in;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		if (r_q.s2 == r_q.s3) begin
			r_d.lvl = r_q.s3;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign level_out = r_q.lvl;
endmodule

// ===== src/mbp_port.sv
`timescale 1ns/10ps
module mbp_port
	import mbp_pkg::*;
(
	input  wire logic                          clk_in,                  // 50 MHz system clock
	input  wire logic                          resetn_in,               // async reset, active low
	// ------------------------------------------------------------
	// core side
	// ------------------------------------------------------------
	input  wire logic                          req_valid_in,            // transfer request
	output logic                               req_ready_out,           // request taken
	input  wire logic                          req_write_in,            // 1 write, 0 read
	input  wire logic [mbp_pkg::BUS_W-1:0]     req_addr_in,             // byte address
	input  wire logic [mbp_pkg::BYTE_LANES-1:0] req_lanes_in,           // byte lanes used
	input  wire logic                          req_miss_in,             // read caused by cache miss
	input  wire logic                          req_ifetch_in,           // miss is instruction fetch
	input  wire logic                          req_burst_in,            // four-word block read
	input  wire logic [mbp_pkg::BUS_W-1:0]     wbuf_data_in,            // write buffer head word
	output logic                               wbuf_pop_out,            // write buffer word used
	output logic                               rbuf_push_out,           // read buffer load strobe
	output logic [mbp_pkg::BUS_W-1:0]          rbuf_data_out,           // read buffer word
	output logic [1:0]                         rbuf_index_out,          // word slot of the load
	output logic                               done_out,                // transfer ended
	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	input  wire logic [mbp_pkg::BUS_W-1:0]     ad_in,                   // shared bus level
	output logic [mbp_pkg::BUS_W-1:0]          ad_out,                  // shared bus drive value
	output logic                               ad_oe_n_out,             // low while we drive bus
	output logic [1:0]                         word_index_out,          // word index pins
	output logic [1:0]                         diag_out,                // diagnostic pins
	output logic                               addr_latch_out,          // address latch strobe
	output logic                               memory_drive_enable_out, // memory may drive bus
	input  wire logic                          read_capture_enable_in,  // memory data valid
	input  wire logic                          ack_in                   // memory acknowledge
);
	import mbp_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		mbp_state_type                st;
		logic [BUS_W-1:0]             addr;
		logic [BYTE_LANES-1:0]        lanes;
		logic                         wr;
		logic                         miss;
		logic                         ifetch;
		logic                         burst;
		logic [2:0]                   cnt;
		logic [1:0]                   idx;
		logic [BUS_W-1:0]             ad;
		logic                         oe_n;
		logic                         ale;
		logic                         den;
		logic [1:0]                   diag;
		logic                         push;
		logic [BUS_W-1:0]             rdata;
		logic [1:0]                   ridx;
		logic                         pop;
		logic                         done;
		logic                         rce_prev;
		logic                         ack_prev;
	} mbp_port_type;

	mbp_port_type r_q;
	mbp_port_type r_d;
	logic         rce_s;
	logic         ack_s;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	mbp_sync u_rce (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.async_in  (read_capture_enable_in),
		.level_out (rce_s)
	);

	mbp_sync u_ack (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.async_in  (ack_in),
		.level_out (ack_s)
	);

	function automatic logic [1:0] addr_diag(input logic [BUS_W-1:0] a);
		addr_diag = {a[DIAG_HI_BIT], a[DIAG_LO_BIT]};
	endfunction

	function automatic logic [BUS_W-1:0] addr_phase(input logic [BUS_W-1:0] a,
		input logic [BYTE_LANES-1:0] l);
		addr_phase = {a[BUS_W-1:ADDR_HI_LSB], l};
	endfunction

	assign req_ready_out = (r_q.st == MBP_IDLE);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		r_d          = r_q;
		r_d.push     = 1'b0;
		r_d.pop      = 1'b0;
		r_d.done     = 1'b0;
		r_d.rce_prev = rce_s;
		r_d.ack_prev = ack_s;
		case (r_q.st)
			MBP_IDLE: begin
				r_d.den  = 1'b0;
				r_d.oe_n = 1'b1;
				if (req_valid_in) begin
					r_d.addr   = req_addr_in;
					r_d.lanes  = req_lanes_in;
					r_d.wr     = req_write_in;
					r_d.miss   = req_miss_in & ~req_write_in;
					r_d.ifetch = req_ifetch_in;
					// single words only unless a read miss asks for a block
					r_d.burst  = req_burst_in & req_miss_in & ~req_write_in;
					r_d.cnt    = CNT_ZERO;
					r_d.ad     = addr_phase(r_d.addr, r_d.lanes);
					r_d.oe_n   = 1'b0;
					r_d.ale    = 1'b1;
					// miss flag forced low on writes, where the pin value is undefined
					r_d.diag   = {r_d.miss, r_d.ifetch};
					if (req_burst_in & req_miss_in & ~req_write_in) begin
						r_d.idx = IDX_ZERO;
					end else begin
						r_d.idx = req_addr_in[IDX_LSB+1:IDX_LSB];
					end
					r_d.st = MBP_ADDR;
				end
			end
			MBP_ADDR: begin
				// strobe drops first; address stays one more cycle for latch hold
				r_d.ale = 1'b0;
				r_d.st  = MBP_HOLD;
			end
			MBP_HOLD: begin
				if (r_q.wr) begin
					r_d.ad  = wbuf_data_in;
					r_d.pop = 1'b1;
					r_d.st  = MBP_WRITE;
				end else begin
					r_d.oe_n = 1'b1;
					r_d.diag = addr_diag(r_q.addr);
					r_d.st   = MBP_READ;
				end
			end
			MBP_WRITE: begin
				r_d.den = 1'b0;
				if (ack_s & ~r_q.ack_prev) begin
					r_d.done = 1'b1;
					r_d.st   = MBP_DONE;
				end
			end
			MBP_READ: begin
				// bus released one cycle earlier, so memory may now drive
				r_d.den = 1'b1;
				if (rce_s & ~r_q.rce_prev) begin
					r_d.push  = 1'b1;
					r_d.rdata = ad_in;
					r_d.ridx  = r_q.idx;
					if (r_q.burst) begin
						r_d.cnt = r_q.cnt + CNT_ONE;
						r_d.idx = r_q.idx + IDX_ONE;
					end
				end
				if (ack_s & ~r_q.ack_prev) begin
					if (!r_q.burst || r_q.cnt == BURST_LAST || r_d.cnt > BURST_LAST) begin
						r_d.done = 1'b1;
						r_d.den  = 1'b0;
						r_d.st   = MBP_DONE;
					end
				end
			end
			MBP_DONE: begin
				r_d.oe_n = 1'b1;
				r_d.den  = 1'b0;
				r_d.st   = MBP_IDLE;
			end
			default: begin
				r_d.st = MBP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r_q      <= '0;
			r_q.st   <= MBP_IDLE;
			r_q.oe_n <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign ad_out                  = r_q.ad;
	assign ad_oe_n_out             = r_q.oe_n;
	assign word_index_out          = r_q.idx;
	assign diag_out                = r_q.diag;
	assign addr_latch_out          = r_q.ale;
	assign memory_drive_enable_out = r_q.den;
	assign rbuf_push_out           = r_q.push;
	assign rbuf_data_out           = r_q.rdata;
	assign rbuf_index_out          = r_q.ridx;
	assign wbuf_pop_out            = r_q.pop;
	assign done_out                = r_q.done;
endmodule

// ===== tb/mbp_monitor.sv
`timescale 1ns/10ps
module mbp_monitor (
	input  wire logic        clk_in, resetn_in, req_valid_in, req_ready_out, req_write_in,
	input  wire logic        req_miss_in, req_ifetch_in, req_burst_in, ad_oe_n_out,
	input  wire logic        addr_latch_out, memory_drive_enable_out, wbuf_pop_out,
	input  wire logic [31:0] req_addr_in, ad_out,
	input  wire logic [3:0]  req_lanes_in,
	input  wire logic [1:0]  word_index_out, diag_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	wire take = req_valid_in && req_ready_out;
	wire rd   = take && !req_write_in;
	a_ale_on_take: assert property (take |=> addr_latch_out) else $error("no strobe");
	a_ale_pulse: assert property (addr_latch_out |=> !addr_latch_out)
		else $error("strobe too long");
	a_addr_high: assert property (take |=> ad_out[31:4] == $past(req_addr_in[31:4]))
		else $error("address bits wrong");
	a_lane_strobes: assert property (take |=> ad_out[3:0] == $past(req_lanes_in))
		else $error("lane strobes wrong");
	a_addr_kept: assert property ($fell(addr_latch_out) |-> $stable(ad_out) && !ad_oe_n_out)
		else $error("address dropped early");
	a_den_released: assert property (memory_drive_enable_out |-> ad_oe_n_out)
		else $error("contention");
	a_den_quiet: assert property (req_ready_out || wbuf_pop_out |-> !memory_drive_enable_out)
		else $error("enable while idle or writing");
	a_miss_flag: assert property (rd |=> diag_out[1] == $past(req_miss_in))
		else $error("miss flag wrong");
	a_fetch_flag: assert property (rd && req_miss_in |=> diag_out[0] == $past(req_ifetch_in))
		else $error("fetch flag wrong");
	a_write_slot: assert property (take && req_write_in |->
		##3 wbuf_pop_out && word_index_out == $past(req_addr_in[3:2], 3)) else $error("write slot");
	a_burst_start: assert property (rd && req_miss_in && req_burst_in |->
		##4 word_index_out == 2'h0) else $error("burst index not zero");
endmodule
bind mbp_port mbp_monitor u_mon (.clk_in(clk_in), .resetn_in(resetn_in),
	.req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_write_in(req_write_in),
	.req_miss_in(req_miss_in), .req_ifetch_in(req_ifetch_in), .req_burst_in(req_burst_in),
	.ad_oe_n_out(ad_oe_n_out), .addr_latch_out(addr_latch_out), .wbuf_pop_out(wbuf_pop_out),
	.memory_drive_enable_out(memory_drive_enable_out), .req_addr_in(req_addr_in),
	.ad_out(ad_out), .req_lanes_in(req_lanes_in), .word_index_out(word_index_out),
	.diag_out(diag_out));

// ===== tb/mbp_memory.sv
`timescale 1ns/10ps
module mbp_memory (
	input  wire logic        clk_in,   // system clock
	input  wire logic [31:0] ad_in,    // device drive value
	input  wire logic        oe_n_in,  // device drives bus when low
	input  wire logic        ale_in,   // address strobe
	input  wire logic        den_in,   // drive enable
	input  wire logic        pop_in,   // write word on bus
	input  wire logic        done_in,  // transfer ended
	input  wire logic [1:0]  idx_in,   // word index
	input  wire logic [2:0]  words_in, // words to return
	input  wire logic [1:0]  dly_in,   // extra wait
	output logic [31:0]      bus_out,  // bus level
	output logic             rce_out,  // capture enable
	output logic             ack_out,  // acknowledge
	output logic [31:0]      lat_out,  // latched address
	output logic [31:0]      wd_out    // last write word
);
	logic [31:0] data, last = 32'h0;
	logic        drv;
	// undriven bus toggles so a stale value never passes
	assign bus_out = !oe_n_in ? ad_in : (drv && den_in) ? data : ~last;
	always @(posedge clk_in) begin
		last <= bus_out;
		if (ale_in) lat_out <= bus_out;
		if (pop_in) wd_out <= bus_out;
	end
	task automatic finish_ack;
		ack_out = 1;
		repeat (40) begin
			@(negedge clk_in);
			if (done_in) break;
		end
		ack_out = 0;
	endtask
	initial begin
		{drv, rce_out, ack_out} = 3'h0;
		data = 32'h0;
		forever begin
			@(negedge clk_in);
			if (den_in) begin
				for (int i = 0; i < words_in; i++) begin
					repeat (dly_in) @(negedge clk_in);
					data = {lat_out[31:4], idx_in, 2'h0} ^ 32'h5A5A_5A5A;
					drv = 1;
					rce_out = 1;
					repeat (6) @(negedge clk_in);
					rce_out = 0;
					repeat (4) @(negedge clk_in);
				end
				finish_ack;
				drv = 0;
			end else if (pop_in) begin
				repeat (dly_in) @(negedge clk_in);
				finish_ack;
			end
		end
	end
endmodule

// ===== tb/mbp_port_bench.sv
`timescale 1ns/10ps
module mbp_port_bench;
	logic clk_in = 0, resetn_in = 0, valid = 0, wr = 0, miss = 0, fetch = 0, burst = 0;
	logic [31:0] addr = 0, wdat = 0, rdat, bus, ad, lat, mwd;
	logic [3:0] lanes = 0;
	logic [2:0] words = 1;
	logic [1:0] dly = 0, ridx, widx, diag;
	logic ready, pop, push, done, oe_n, ale, den, rce, ack;
	int n_mismatch = 0, tests_run = 0, seed = 32'h05a2028d;
	mbp_port uut (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(valid),
		.req_ready_out(ready), .req_write_in(wr), .req_addr_in(addr), .req_lanes_in(lanes),
		.req_miss_in(miss), .req_ifetch_in(fetch), .req_burst_in(burst), .wbuf_data_in(wdat),
		.wbuf_pop_out(pop), .rbuf_push_out(push), .rbuf_data_out(rdat), .rbuf_index_out(ridx),
		.done_out(done), .ad_in(bus), .ad_out(ad), .ad_oe_n_out(oe_n), .word_index_out(widx),
		.diag_out(diag), .addr_latch_out(ale), .memory_drive_enable_out(den),
		.read_capture_enable_in(rce), .ack_in(ack));
	mbp_memory mem (.clk_in(clk_in), .ad_in(ad), .oe_n_in(oe_n), .ale_in(ale), .den_in(den),
		.pop_in(pop), .done_in(done), .idx_in(widx), .words_in(words), .dly_in(dly),
		.bus_out(bus), .rce_out(rce), .ack_out(ack), .lat_out(lat), .wd_out(mwd));
	initial forever #10 clk_in = ~clk_in;
	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] word_of(input logic [31:0] a, input logic [1:0] i);
		return {a[31:4], i, 2'h0} ^ 32'h5A5A_5A5A;
	endfunction
	task automatic xfer(input logic w, input logic [31:0] a, input logic [3:0] l,
		input logic m, f, b);
		int n;
		logic bst;
		n = 0;
		bst = !w && m && b;
		@(posedge clk_in);
		#1 {valid, wr, addr, lanes, miss, fetch, burst} = {1'b1, w, a, l, m, f, b};
		wdat = $random(seed);
		dly = $random(seed);
		words = bst ? 3'h4 : 3'h1;
		while (!ready) begin
			@(posedge clk_in);
			#1;
		end
		@(posedge clk_in);
		#1 valid = 0;
		check("strobe", ale, 1);
		check("bus address", ad, {a[31:4], l});
		if (!w) check("miss flag", diag[1], m);
		if (!w && m) check("fetch flag", diag[0], f);
		repeat (300) begin
			@(posedge clk_in);
			#1;
			if (push) begin
				check("read word", rdat, word_of(a, bst ? n[1:0] : a[3:2]));
				if (bst) check("slot", ridx, n);
				check("late diag", diag, a[3:2]);
				n++;
			end
			if (done) break;
		end
		check("done", done, 1);
		if (w) begin
			check("write word", mwd, wdat);
			check("write slot", widx, a[3:2]);
		end else check("words", n, words);
		check("latched address", lat, {a[31:4], l});
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge clk_in);
		#1 resetn_in = 1;
		xfer(1, 32'hFFFF_FFFC, 4'hF, 0, 0, 0);
		xfer(0, 32'h0000_000C, 4'h1, 1, 1, 1);
		xfer(0, 32'h1234_5678, 4'h3, 0, 0, 1);
		xfer(0, 32'h8000_0004, 4'hF, 1, 0, 0);
		repeat (40) xfer($random(seed), $random(seed), $random(seed), $random(seed),
			$random(seed), $random(seed));
		close_out;
	end
endmodule
